// [rtl/eptc_pkg.sv]
// package of constants and carrier types for the two-wire eeprom control block
package eptc_pkg;
    // clock rate and glitch filter
    localparam int unsigned CLK_PERIOD_NS    = 10;
    localparam int unsigned GLITCH_NS        = 130;
    // filter cycles: a pulse must outlast the glitch width to pass
    localparam int unsigned GLITCH_CYC       = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
    // initialization interval after power-on clear release
    localparam int unsigned INIT_CYC         = 1000;
    // frame layout
    localparam int unsigned ADDR_BITS        = 7;
    localparam int unsigned BYTE_BITS        = 8;
    localparam logic [6:0]  DEV_ADDR_DEFAULT = 7'h50; // arbitrary target address
    localparam logic [3:0]  BIT_CNT_ACK      = 4'h8;
    localparam logic [3:0]  BIT_CNT_RESET    = 4'h0;

    // bus decoder states, one-hot
    typedef enum logic [5:0] {
        EPTC_INIT  = 6'h01,
        EPTC_IDLE  = 6'h02,
        EPTC_ADDR  = 6'h04,
        EPTC_DATA  = 6'h08,
        EPTC_ACK   = 6'h10,
        EPTC_IGN   = 6'h20
    } eptc_state_t;

    // filtered bus levels
    typedef struct packed {
        logic scl;
        logic sda;
    } eptc_bus_t;

    // write commit request carried out of the block
    typedef struct packed {
        logic       valid;
        logic [7:0] count;
    } eptc_commit_t;
endpackage

// [rtl/eptc_filter.sv]
// glitch filter for one serial input line
module eptc_filter #(
    parameter int unsigned FILT_CYC = eptc_pkg::GLITCH_CYC
) (
    // clock and reset
    input  wire logic ref_clk_in,
    input  wire logic rst_in,
    // raw and filtered line
    input  wire logic raw_in,
    output logic      filt_out
);
    typedef struct packed {
        logic       level;   // accepted level
        logic [7:0] cnt;     // cycles the raw level has differed
    } eptc_filt_state_t;

    eptc_filt_state_t s_q;
    eptc_filt_state_t s_d;

    // a level change is taken only after it stands FILT_CYC cycles in a row
    always_comb begin
        s_d = s_q;
        if (raw_in == s_q.level) begin
            s_d.cnt = 8'h00;
        end else if (s_q.cnt == 8'(FILT_CYC - 1)) begin
            s_d.level = raw_in;
            s_d.cnt   = 8'h00;
        end else begin
            s_d.cnt = s_q.cnt + 8'h01;
        end
    end

    // idle bus is high, so reset the level high
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            s_q <= '{level: 1'b1, cnt: 8'h00};
        end else begin
            s_q <= s_d;
        end
    end

    assign filt_out = s_q.level;
endmodule

// [rtl/eptc_ctrl.sv]
// two-wire eeprom target control: power-up gating, glitch filter, write commit, start cancel
//
// Function
// - ignore bus instructions during power-on initialization
// - enter idle standby after initialization completes
// - commit write only after byte ack then stop
// - start during command aborts and restarts decoding
// - filter pulses of 130 ns or shorter
// - address seven bits plus direction, acknowledged
module eptc_ctrl #(
    parameter int unsigned INIT_LEN = eptc_pkg::INIT_CYC,
    parameter logic [6:0]  DEV_ADDR = eptc_pkg::DEV_ADDR_DEFAULT
) (
    // clock and power-on clear
    input  wire logic ref_clk_in,
    input  wire logic rst_in,
    // serial bus pins, data is open drain
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe_out,
    // status and write commit
    output logic      ready_out,
    output logic      rd_dir_out,
    output logic      commit_out,
    output logic [7:0] commit_cnt_out,
    output logic      cancel_out
);
    // filtered lines from the glitch filters
    // nothing below reads the raw pins; a raw edge could be taken for a start or stop
    // while the other line is still inside its filter window
    logic scl_f;
    logic sda_f;

    // complete block state; everything the decoder remembers lives here, so that one
    // always_comb builds the next copy and one always_ff registers it
    // the init counter is sixteen bits wide, which bounds the longest interval
    // that the INIT_LEN parameter can ask for
    typedef struct packed {
        eptc_pkg::eptc_state_t  st;        // decoder state
        logic [15:0]            init_cnt;  // initialization countdown
        eptc_pkg::eptc_bus_t    prev;      // filtered levels one cycle ago
        logic [3:0]             bit_cnt;   // bit position in current byte
        logic [7:0]             shreg;     // incoming byte
        logic                   rd_dir;    // direction flag of the frame
        logic                   is_addr;   // ack belongs to address byte
        logic                   ack_done;  // last event was a data byte ack
        logic [7:0]             nbytes;    // acknowledged data bytes
        logic                   sda_drv;   // pulling data low
        logic                   ready;     // standby reached
        eptc_pkg::eptc_commit_t commit;    // write commit pulse
        logic                   cancel;    // command cancel pulse
    } eptc_ctrl_regs_t;

    eptc_ctrl_regs_t s_q;  // registered state
    eptc_ctrl_regs_t s_d;  // next state

    // one filter per line
    // both lines use the same length, so clock and data keep their order after filtering;
    // a longer filter on one line would skew start and stop detection
    eptc_filter #(.FILT_CYC(eptc_pkg::GLITCH_CYC)) u_scl_filt (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .raw_in     (scl_in),
        .filt_out   (scl_f)
    );
    eptc_filter #(.FILT_CYC(eptc_pkg::GLITCH_CYC)) u_sda_filt (
        .ref_clk_in (ref_clk_in),
        .rst_in     (rst_in),
        .raw_in     (sda_in),
        .filt_out   (sda_f)
    );

    // bus events derived from filtered levels only
    // each event lasts one cycle, since prev always holds the filtered level of the cycle before
    // limitation: events are seen about fifteen cycles after the pins move, so a master
    // must keep data steady for longer than that after the clock falls
    // a start is data falling while clock stays high, a stop is data rising while clock stays high
    logic start_ev;
    logic stop_ev;
    logic scl_rise;
    logic scl_fall;
    assign start_ev = s_q.prev.scl & scl_f & s_q.prev.sda & ~sda_f;
    assign stop_ev  = s_q.prev.scl & scl_f & ~s_q.prev.sda & sda_f;
    assign scl_rise = ~s_q.prev.scl & scl_f;
    assign scl_fall = s_q.prev.scl & ~scl_f;

    // next-state logic
    // a write walks IDLE, ADDR, ACK, DATA, ACK, ... and ends at a stop; the commit pulse is
    // raised only when the stop follows a data byte ack with no whole clock pulse between
    // a start anywhere past INIT restarts at ADDR, which is also how a stuck frame is cleared
    // during INIT the events are still computed but nothing acts on them, so a frame that
    // straddles the end of the interval is simply never decoded
    // pulses are cleared by default here, so each stands exactly one cycle
    always_comb begin
        s_d             = s_q;
        s_d.prev        = '{scl: scl_f, sda: sda_f};
        s_d.commit      = '{valid: 1'b0, count: s_q.commit.count};
        s_d.cancel      = 1'b0;
        unique case (s_q.st)
            eptc_pkg::EPTC_INIT: begin
                // bus is not looked at until the interval expires
                // the count runs from the release of the power-on clear, so a pin that
                // toggles during the interval can never leave a half decoded command behind
                if (s_q.init_cnt == 16'h0000) begin
                    s_d.st    = eptc_pkg::EPTC_IDLE;
                    s_d.ready = 1'b1;
                end else begin
                    s_d.init_cnt = s_q.init_cnt - 16'h0001;
                end
            end
            // every state past the interval reacts to start and stop the same way; IGN
            // covers a foreign address and the read data phase, which lies outside this block
            // a read frame therefore never drives data here, only its address is acknowledged
            eptc_pkg::EPTC_IDLE,
            eptc_pkg::EPTC_ADDR,
            eptc_pkg::EPTC_DATA,
            eptc_pkg::EPTC_ACK,
            eptc_pkg::EPTC_IGN: begin
                if (start_ev) begin
                    // a start while busy drops the command; any state but IDLE counts as busy
                    // a start from idle is an ordinary frame opening, so no cancel pulse then
                    // the byte count is cleared too, so a cancelled write can never commit later
                    s_d.cancel   = (s_q.st != eptc_pkg::EPTC_IDLE);
                    s_d.st       = eptc_pkg::EPTC_ADDR;
                    s_d.bit_cnt  = eptc_pkg::BIT_CNT_RESET;
                    s_d.nbytes   = 8'h00;
                    s_d.ack_done = 1'b0;
                    s_d.sda_drv  = 1'b0;
                end else if (stop_ev) begin
                    // write only if a data byte ack was the very last event
                    // a stop after the address alone, or inside a byte, leaves memory untouched
                    // the count of the last commit is held on its output until the next one
                    if (s_q.ack_done && !s_q.rd_dir && s_q.nbytes != 8'h00) begin
                        s_d.commit = '{valid: 1'b1, count: s_q.nbytes};
                    end
                    s_d.st      = eptc_pkg::EPTC_IDLE;
                    s_d.sda_drv = 1'b0;
                end else if (s_q.st == eptc_pkg::EPTC_ADDR || s_q.st == eptc_pkg::EPTC_DATA) begin
                    if (scl_rise) begin
                        // shift on the rise; a rise alone is not yet a clocked bit, because the
                        // clock also rises just before a stop and that must not break the pairing
                        s_d.shreg   = {s_q.shreg[6:0], sda_f};
                        s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                    end else if (scl_fall) begin
                        // a whole clock pulse after the ack breaks the stop-after-ack pairing
                        s_d.ack_done = 1'b0;
                        if (s_q.bit_cnt == eptc_pkg::BIT_CNT_ACK) begin
                            // eighth bit done: decide whether to acknowledge
                            s_d.is_addr = (s_q.st == eptc_pkg::EPTC_ADDR);
                            if (s_q.st == eptc_pkg::EPTC_ADDR) begin
                                // seven address bits then the direction flag
                                if (s_q.shreg[7:1] == DEV_ADDR) begin
                                    s_d.rd_dir  = s_q.shreg[0];
                                    s_d.sda_drv = 1'b1;
                                    s_d.st      = eptc_pkg::EPTC_ACK;
                                end else begin
                                    // another target is addressed: stay silent until start or stop
                                    s_d.st = eptc_pkg::EPTC_IGN;
                                end
                            end else begin
                                // every received data byte is acknowledged
                                s_d.sda_drv = 1'b1;
                                s_d.st      = eptc_pkg::EPTC_ACK;
                            end
                        end
                    end
                end else if (s_q.st == eptc_pkg::EPTC_ACK) begin
                    // release data after the ack clock falls
                    // releasing on the filtered fall leaves the line low well past the clock edge
                    if (scl_fall) begin
                        s_d.sda_drv = 1'b0;
                        s_d.bit_cnt = eptc_pkg::BIT_CNT_RESET;
                        // read data path lies outside this block, so reads go quiet
                        s_d.st      = s_q.rd_dir ? eptc_pkg::EPTC_IGN : eptc_pkg::EPTC_DATA;
                        if (!s_q.is_addr) begin
                            s_d.nbytes   = s_q.nbytes + 8'h01;
                            s_d.ack_done = 1'b1;
                        end
                    end
                end
            end
        endcase
    end

    // state register; power-on clear loads the interval
    // the reset is synchronous, so the clear must stand for at least one clock edge
    // prev resets to the idle high levels, so no false start or stop follows reset
    // every field is given a constant here; nothing from the bus leaks into reset
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            s_q.st       <= eptc_pkg::EPTC_INIT;
            s_q.init_cnt <= 16'(INIT_LEN);
            s_q.prev     <= '{scl: 1'b1, sda: 1'b1};
            s_q.bit_cnt  <= eptc_pkg::BIT_CNT_RESET;
            s_q.shreg    <= 8'h00;
            s_q.rd_dir   <= 1'b0;
            s_q.is_addr  <= 1'b0;
            s_q.ack_done <= 1'b0;
            s_q.nbytes   <= 8'h00;
            s_q.sda_drv  <= 1'b0;
            s_q.ready    <= 1'b0;
            s_q.commit   <= '{valid: 1'b0, count: 8'h00};
            s_q.cancel   <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    // data is open drain: only the enable moves, the level driven is always low
    // the enable is high while the block pulls the line down for an acknowledge
    assign sda_out        = 1'b0;
    assign sda_oe_out     = s_q.sda_drv;
    assign ready_out      = s_q.ready;
    assign rd_dir_out     = s_q.rd_dir;
    assign commit_out     = s_q.commit.valid;
    assign commit_cnt_out = s_q.commit.count;
    assign cancel_out     = s_q.cancel;
endmodule

// [verification/eptc_ctrl_properties.sv]
// port assertions of the eeprom control block
module eptc_props #(
    parameter int unsigned INIT_LEN = 1000
) (
    // clock and power-on clear
    input wire logic       ref_clk_in,
    input wire logic       rst_in,
    // bus pins and status
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_out,
    input wire logic       ready_out,
    input wire logic       rd_dir_out,
    input wire logic       commit_out,
    input wire logic [7:0] commit_cnt_out,
    input wire logic       cancel_out
);
    logic [15:0] age_q; // cycles since release, saturating so it never wraps to zero
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) age_q <= 16'h0000;
        else if (age_q != 16'hFFFF) age_q <= age_q + 16'h0001;
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    AST_IGNORE_INIT: assert property (!ready_out |-> !sda_oe_out) else $error("ack before ready");
    AST_READY_HOLD: assert property (ready_out |=> ready_out) else $error("ready dropped");
    AST_INIT_END: assert property (age_q > INIT_LEN + 3 |-> ready_out) else $error("init long");
    AST_INIT_MIN: assert property ($rose(ready_out) |-> age_q == INIT_LEN + 1) else $error("init length wrong");
    AST_COMMIT_STOP: assert property (commit_out |-> (scl_in && sda_in && commit_cnt_out != 8'h00) ##1 !commit_out)
        else $error("bad commit");
    AST_CANCEL_START: assert property (cancel_out |-> (scl_in && !sda_in) ##1 !cancel_out) else $error("bad cancel");
    AST_ACK_SCL_LOW: assert property ($rose(sda_oe_out) |-> !scl_in && !$past(scl_in, 14))
        else $error("ack timing");
    AST_ACK_HOLD: assert property ($rose(sda_oe_out) |=> sda_oe_out [*8]) else $error("ack short");
    cover property (commit_out);
    cover property (cancel_out);
    cover property ($rose(sda_oe_out));
endmodule

bind eptc_ctrl eptc_props #(.INIT_LEN(INIT_LEN)) eptc_props_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .ready_out(ready_out),
    .rd_dir_out(rd_dir_out), .commit_out(commit_out), .commit_cnt_out(commit_cnt_out), .cancel_out(cancel_out));

// [verification/eptc_mdl.sv]
// bus master model driving clock and data of the eeprom block
module eptc_mdl (
    // clock and resolved data line
    input  wire logic ref_clk_in,
    input  wire logic sda_in,
    // driven clock and data pull-down
    output logic      scl_out = 1'b1,
    output logic      sda_oe_out = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int Q = 32; // quarter bit, keeps data changes well clear of clock edges
    // set both lines on the falling edge and hold them a quarter bit
    task automatic step(input logic c, input logic d);
        scl_out = c;
        sda_oe_out = d;
        repeat (Q) @(negedge ref_clk_in);
    endtask
    // data released before clock rises, so a start never fights a low data line
    task automatic bus_start();
        step(scl_out, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask
    task automatic bus_stop();
        step(1'b0, 1'b1);
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        step(1'b1, 1'b0);
    endtask
    // one clocked bit, line sampled in mid clock high
    task automatic send_bit(input logic b, output logic seen);
        step(1'b0, !b);
        step(1'b1, !b);
        seen = sda_in;
        step(1'b1, !b);
        step(1'b0, !b);
    endtask
    // msb first, then a released ninth bit returns the acknowledge
    task automatic send_byte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) send_bit(v[i], s);
        send_bit(1'b1, s);
        ack = !s;
    endtask
    // realign: start, nine released clocks, start, stop
    task automatic realign();
        logic s;
        bus_start();
        repeat (9) send_bit(1'b1, s);
        bus_start();
        bus_stop();
    endtask
    // clock pulse too short to be a bit
    task automatic scl_glitch(input int w);
        scl_out = 1'b1;
        repeat (w) @(negedge ref_clk_in);
        step(1'b0, sda_oe_out);
    endtask
endmodule

// [verification/tb_eptc_ctrl.sv]
// self-checking bench of the eeprom control block
module tb_eptc_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int unsigned IL  = 3000; // long enough to hide a whole frame inside init
    localparam logic [6:0]  DEV = 7'h50;
    logic       ref_clk_in = 1'b0;
    logic       rst_in = 1'b1;
    logic       scl, m_oe, d_oe, d_o, rdy, rd, cmt, cnl, ack;
    logic [7:0] cnt, last_cnt;
    int         bad_count = 0, n_tests = 0, n_cmt = 0, n_cnl = 0, nb, s;
    wire        sda = !(m_oe || (d_oe && !d_o)); // pulled-up open-drain line
    eptc_ctrl #(.INIT_LEN(IL), .DEV_ADDR(DEV)) eptc_ctrl_inst (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .scl_in(scl), .sda_in(sda), .sda_out(d_o), .sda_oe_out(d_oe), .ready_out(rdy), .rd_dir_out(rd),
        .commit_out(cmt), .commit_cnt_out(cnt), .cancel_out(cnl));
    eptc_mdl eptc_mdl_inst (.ref_clk_in(ref_clk_in), .sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));
    initial forever #5 ref_clk_in = !ref_clk_in;
    // pulses stand one cycle, so count them on the edge
    always @(posedge ref_clk_in) begin
        n_cmt <= n_cmt + int'(cmt === 1'b1);
        n_cnl <= n_cnl + int'(cnl === 1'b1);
        if (cmt === 1'b1) last_cnt <= cnt;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    function automatic logic exp_commit(input int n, input logic direct);
        return n >= 1 && direct;
    endfunction
    // start, address byte, then n random data bytes with their acks compared
    task automatic frame(input logic [6:0] a, input logic dir, input int n);
        logic hit;
        hit = a == DEV && rdy === 1'b1;
        eptc_mdl_inst.bus_start();
        eptc_mdl_inst.send_byte({a, dir}, ack);
        check(ack, hit);
        for (int i = 0; i < n; i++) begin
            eptc_mdl_inst.send_byte(8'($urandom), ack);
            check(ack, hit && !dir);
        end
    endtask
    task automatic stop_chk(input logic e, input logic [7:0] n);
        int b;
        b = n_cmt;
        eptc_mdl_inst.bus_stop();
        check(8'(n_cmt - b), {7'h00, e});
        if (e) check(last_cnt, n);
    endtask
    initial begin
        s = $urandom(60121);
        repeat (16) @(negedge ref_clk_in);
        rst_in = 1'b0;
        frame(DEV, 1'b0, 1);
        stop_chk(1'b0, 8'h00);
        for (int i = 0; i < IL && rdy !== 1'b1; i++) @(negedge ref_clk_in);
        check(rdy, 1'b1);
        // a timed-out wait skips straight to the verdict with its mismatch counted
        if (rdy === 1'b1) begin
            check(d_o, 1'b0);
            eptc_mdl_inst.realign();
            check(8'(n_cmt), 8'h00);
            // random writes, the first with no data byte
            for (int i = 0; i < 5; i++) begin
                nb = (i == 0) ? 0 : $urandom_range(1, 3);
                frame(DEV, 1'b0, nb);
                stop_chk(exp_commit(nb, 1'b1), 8'(nb));
            end
            check(rd, 1'b0);
            frame(DEV ^ 7'h01, 1'b0, 1);
            stop_chk(1'b0, 8'h00);
            frame(DEV, 1'b1, 0);
            check(rd, 1'b1);
            stop_chk(1'b0, 8'h00);
            frame(DEV, 1'b0, 2);
            eptc_mdl_inst.send_bit(1'b1, ack);
            stop_chk(exp_commit(2, 1'b0), 8'h00);
            // start in mid byte, then a fresh frame reloads the address
            nb = n_cnl;
            frame(DEV, 1'b0, 1);
            for (int i = 0; i < 3; i++) eptc_mdl_inst.send_bit(1'b0, ack);
            frame(DEV, 1'b0, 2);
            check(8'(n_cnl - nb), 8'h01);
            stop_chk(1'b1, 8'h02);
            frame(DEV, 1'b0, 1);
            eptc_mdl_inst.scl_glitch(13);
            stop_chk(1'b1, 8'h01);
        end
        give_verdict();
    end
endmodule
